// file: src/sysclk_pkg.sv
// constants, field layouts and carriers of the system clock and pll control block
// assumes one pclk domain at 250 MHz and an apb master with 32-bit data
package sysclk_pkg;

   // register byte offsets
   localparam logic [11:0] RIS_OFF = 12'h050;
   localparam logic [11:0] IMC_OFF = 12'h054;
   localparam logic [11:0] MISC_OFF = 12'h058;
   localparam logic [11:0] RUN_CLOCK_CFG_OFF = 12'h060;
   localparam logic [11:0] PLL_TRANSLATION_OFF = 12'h064;
   localparam logic [11:0] RUN_CLOCK_CFG_EXT_OFF = 12'h070;

   // reset values
   localparam logic [31:0] RUN_CLOCK_CFG_RST = 32'h07ae3ad1;
   localparam logic [31:0] RUN_CLOCK_CFG_EXT_RST = 32'h07802800;

   // run_clock_cfg fields
   localparam int CRYSTAL_OSC_DIS_BIT = 0;
   localparam int OSC_SRC_LSB = 4;
   localparam int CRYSTAL_SELECT_LSB = 6;
   localparam int BYPASS_BIT = 11;
   localparam int PWRDN_BIT = 13;
   localparam int USESYS_BIT = 22;
   localparam int SYSDIV_LSB = 23;
   // run_clock_cfg_ext fields
   localparam int OSC_SRC2_LSB = 4;
   localparam int SYSDIV2_LSB = 23;
   localparam int EXT_SEL_BIT = 31;
   // interrupt bit of pll lock
   localparam int LOCK_BIT = 6;

   // writable bits
   localparam logic [31:0] RUN_CLOCK_CFG_WMASK = 32'h07c02bf1;
   localparam logic [31:0] RUN_CLOCK_CFG_EXT_WMASK = 32'h9f802870;
   localparam logic [31:0] INT_MASK = 32'h00000040;

   // relock counter load
   localparam logic [12:0] RELOCK_LOAD = 13'h1200;
   // break-before-make gap counter load, in pclk cycles; all lanes stay off for one cycle more than this
   localparam logic [3:0] SWITCH_GAP = 4'h4;

   // clock source codes (3-bit field value)
   localparam logic [2:0] SRC_CRYSTAL = 3'h0;
   localparam logic [2:0] SRC_FAST = 3'h1;
   localparam logic [2:0] SRC_FAST_DIV4 = 3'h2;
   localparam logic [2:0] SRC_SLOW = 3'h3;
   localparam logic [2:0] SRC_RTC = 3'h7;

   // one-hot clock select lanes
   localparam int SEL_CRYSTAL = 0;
   localparam int SEL_FAST = 1;
   localparam int SEL_FAST_DIV4 = 2;
   localparam int SEL_SLOW = 3;
   localparam int SEL_RTC = 4;
   localparam int SEL_PLL = 5;

   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_s;

   typedef struct packed {
      logic [2:0] osc_src;
      logic bypass;
      logic pwrdn;
      logic [5:0] sysdiv;
   } clk_cfg_s;

endpackage

// file: src/sysclk_ctrl.sv
// system clock source selection, pll control and relock timing with apb registers
// assumes an external glitch-free-capable clock gate per one-hot select lane,
// and crystal_osc_in at less than half the pclk rate
//
// Overview of operation
// [RL1] sysclk from one of six sources
// [RL2] fast internal oscillator used from reset
// [RL3] software enables, settles crystal before selecting
// [RL4] extended config fields override basic ones
// [RL5] crystal number translated into pll settings
// [RL6] translation readable, within one percent
// [RL7] crystal change recomputes pll translation
// [RL8] pll off after reset until enabled
// [RL9] pll normal drives, power-down does not
// [RL10] relock on crystal change or power-up
// [RL11] crystal-clocked down counter loaded 0x1200
// [RL12] pll unselectable until relock count done
// [RL13] software ensures stable reference before pll
// [RL14] software keeps reference in allowed range
// [RL15] software sets source, divisor, then enables
// [RL16] extended fields only while select set
// [RL17] lock completion sets raw flag, polled
// [RL18] source switching without truncated phases
//
// Our own choices: the register addresses and the APB slave port.
module sysclk_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic crystal_osc_in,
   output logic [5:0] clk_sel,
   output logic crystal_osc_en,
   output logic pll_pwrdn,
   output logic [13:0] pll_translation_value,
   output logic [5:0] sysdiv,
   output logic use_sysdiv,
   output logic irq
);

   typedef enum logic [2:0] {
      SW_RUN = 3'b001,
      SW_GAP = 3'b010,
      SW_SET = 3'b100
   } sw_state_e;

   // crystal number to pll multiplier for a 400 MHz vco, zero where pll use is unsupported
   function automatic logic [13:0] crystal_to_mult(input logic [3:0] sel);
      logic [13:0] m;
      m = 14'h0000;
      case (sel)
         4'h4: m = 14'h0070;
         4'h5: m = 14'h006d;
         4'h6: m = 14'h0064;
         4'h7: m = 14'h0062;
         4'h8: m = 14'h0051;
         4'h9: m = 14'h0050;
         4'ha: m = 14'h004e;
         4'hb: m = 14'h0043;
         4'hc: m = 14'h0041;
         4'hd: m = 14'h0036;
         4'he: m = 14'h0032;
         4'hf: m = 14'h0031;
         default: m = 14'h0000;
      endcase
      return m;
   endfunction

   function automatic logic [5:0] src_onehot(input logic [2:0] src);
      logic [5:0] oh;
      oh = 6'h00;
      case (src)
         sysclk_pkg::SRC_CRYSTAL: oh[sysclk_pkg::SEL_CRYSTAL] = 1'b1;
         sysclk_pkg::SRC_FAST: oh[sysclk_pkg::SEL_FAST] = 1'b1;
         sysclk_pkg::SRC_FAST_DIV4: oh[sysclk_pkg::SEL_FAST_DIV4] = 1'b1;
         sysclk_pkg::SRC_SLOW: oh[sysclk_pkg::SEL_SLOW] = 1'b1;
         sysclk_pkg::SRC_RTC: oh[sysclk_pkg::SEL_RTC] = 1'b1;
         default: oh[sysclk_pkg::SEL_FAST] = 1'b1;
      endcase
      return oh;
   endfunction

   sysclk_pkg::apb_req_s req;
   sysclk_pkg::clk_cfg_s cfg;
   logic [31:0] run_clock_cfg_q;
   logic [31:0] run_clock_cfg_ext_q;
   logic [31:0] imc_q;
   logic [31:0] ris_q;
   logic [31:0] rdata_d;
   logic mapped;
   logic wr_fire;
   logic [3:0] crystal_select_q;
   logic [3:0] crystal_field;
   logic pwrdn_prev_q;
   logic relock_pend_q;
   logic [12:0] relock_cnt_q;
   logic pll_ready_q;
   logic lock_set;
   logic xo_s1_q;
   logic xo_s2_q;
   logic xo_s3_q;
   logic xo_rise;
   logic [5:0] target;
   sw_state_e sw_q;
   logic [3:0] gap_q;
   logic [5:0] pending_q;

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign wr_fire = psel & penable & pready & req.write;
   assign crystal_field = run_clock_cfg_q[sysclk_pkg::CRYSTAL_SELECT_LSB +: 4];

   // [RL4] [RL16] extended fields govern only while their select bit is set
   always_comb begin
      if (run_clock_cfg_ext_q[sysclk_pkg::EXT_SEL_BIT]) begin
         cfg.osc_src = run_clock_cfg_ext_q[sysclk_pkg::OSC_SRC2_LSB +: 3];
         cfg.bypass = run_clock_cfg_ext_q[sysclk_pkg::BYPASS_BIT];
         cfg.pwrdn = run_clock_cfg_ext_q[sysclk_pkg::PWRDN_BIT];
         cfg.sysdiv = run_clock_cfg_ext_q[sysclk_pkg::SYSDIV2_LSB +: 6];
      end else begin
         cfg.osc_src = {1'b0, run_clock_cfg_q[sysclk_pkg::OSC_SRC_LSB +: 2]};
         cfg.bypass = run_clock_cfg_q[sysclk_pkg::BYPASS_BIT];
         cfg.pwrdn = run_clock_cfg_q[sysclk_pkg::PWRDN_BIT];
         cfg.sysdiv = {2'b00, run_clock_cfg_q[sysclk_pkg::SYSDIV_LSB +: 4]};
      end
   end

   always_comb begin
      mapped = 1'b1;
      rdata_d = 32'h00000000;
      case (req.addr)
         sysclk_pkg::RIS_OFF: rdata_d = ris_q;
         sysclk_pkg::IMC_OFF: rdata_d = imc_q;
         sysclk_pkg::MISC_OFF: rdata_d = ris_q & imc_q;
         sysclk_pkg::RUN_CLOCK_CFG_OFF: rdata_d = run_clock_cfg_q;
         sysclk_pkg::PLL_TRANSLATION_OFF: rdata_d = {18'h00000, pll_translation_value}; // [RL6]
         sysclk_pkg::RUN_CLOCK_CFG_EXT_OFF: rdata_d = run_clock_cfg_ext_q;
         default: mapped = 1'b0;
      endcase
   end

   // one wait state: ready rises one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~req.write) ? rdata_d : 32'h00000000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // [RL2] [RL8] reset values select the fast oscillator with the pll powered down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_clock_cfg_q <= sysclk_pkg::RUN_CLOCK_CFG_RST;
         run_clock_cfg_ext_q <= sysclk_pkg::RUN_CLOCK_CFG_EXT_RST;
         imc_q <= 32'h00000000;
      end else if (clk_en && wr_fire) begin
         case (req.addr)
            sysclk_pkg::RUN_CLOCK_CFG_OFF:
               run_clock_cfg_q <= req.wdata & sysclk_pkg::RUN_CLOCK_CFG_WMASK;
            sysclk_pkg::RUN_CLOCK_CFG_EXT_OFF:
               run_clock_cfg_ext_q <= req.wdata & sysclk_pkg::RUN_CLOCK_CFG_EXT_WMASK;
            sysclk_pkg::IMC_OFF: imc_q <= req.wdata & sysclk_pkg::INT_MASK;
            default: ;
         endcase
      end
   end

   // [RL17] sticky lock flag, write one to clear; a lock in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ris_q <= 32'h00000000;
      end else if (clk_en) begin
         if (lock_set) begin
            ris_q[sysclk_pkg::LOCK_BIT] <= 1'b1;
         end else if (wr_fire && req.addr == sysclk_pkg::MISC_OFF &&
                      req.wdata[sysclk_pkg::LOCK_BIT]) begin
            ris_q[sysclk_pkg::LOCK_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(ris_q & imc_q);
      end
   end

   // crystal clock sampled as a level; its edges pace the relock count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xo_s1_q <= 1'b0;
         xo_s2_q <= 1'b0;
         xo_s3_q <= 1'b0;
      end else if (clk_en) begin
         xo_s1_q <= crystal_osc_in;
         xo_s2_q <= xo_s1_q;
         xo_s3_q <= xo_s2_q;
      end
   end
   assign xo_rise = xo_s2_q & ~xo_s3_q;

   // [RL5] [RL7] translation follows every change of the crystal field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_select_q <= sysclk_pkg::RUN_CLOCK_CFG_RST[sysclk_pkg::CRYSTAL_SELECT_LSB +: 4];
         pll_translation_value <= crystal_to_mult(
            sysclk_pkg::RUN_CLOCK_CFG_RST[sysclk_pkg::CRYSTAL_SELECT_LSB +: 4]);
         pwrdn_prev_q <= 1'b1;
      end else if (clk_en) begin
         crystal_select_q <= crystal_field;
         pll_translation_value <= crystal_to_mult(crystal_field);
         pwrdn_prev_q <= cfg.pwrdn;
      end
   end

   // [RL10] [RL11] relock on crystal change or power-up; stalls if the crystal is stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relock_cnt_q <= 13'h0000;
         relock_pend_q <= 1'b0;
         pll_ready_q <= 1'b0;
         lock_set <= 1'b0;
      end else if (clk_en) begin
         lock_set <= 1'b0;
         if (cfg.pwrdn) begin
            pll_ready_q <= 1'b0; // [RL9]
            relock_pend_q <= 1'b0;
         end else if (crystal_select_q != crystal_field || pwrdn_prev_q) begin
            relock_cnt_q <= sysclk_pkg::RELOCK_LOAD;
            relock_pend_q <= 1'b1;
            pll_ready_q <= 1'b0;
         end else if (relock_pend_q && xo_rise) begin
            if (relock_cnt_q == 13'h0001 || relock_cnt_q == 13'h0000) begin
               relock_cnt_q <= 13'h0000;
               relock_pend_q <= 1'b0;
               pll_ready_q <= 1'b1;
               lock_set <= 1'b1;
            end else begin
               relock_cnt_q <= relock_cnt_q - 13'h0001;
            end
         end
      end
   end

   // [RL1] [RL12] pll only once relocked and bypass cleared, else the raw source
   always_comb begin
      if (!cfg.bypass && pll_ready_q) begin
         target = 6'h00;
         target[sysclk_pkg::SEL_PLL] = 1'b1;
      end else begin
         target = src_onehot(cfg.osc_src);
      end
   end

   // [RL18] break before make: all lanes off for a gap so no phase is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q <= SW_RUN;
         gap_q <= 4'h0;
         pending_q <= 6'h02;
         clk_sel <= 6'h02;
      end else if (clk_en) begin
         case (sw_q)
            SW_RUN: begin
               if (target != clk_sel) begin
                  clk_sel <= 6'h00;
                  pending_q <= target;
                  gap_q <= sysclk_pkg::SWITCH_GAP;
                  sw_q <= SW_GAP;
               end
            end
            SW_GAP: begin
               if (gap_q == 4'h1) begin
                  sw_q <= SW_SET;
               end
               gap_q <= gap_q - 4'h1;
            end
            SW_SET: begin
               clk_sel <= pending_q;
               sw_q <= SW_RUN;
            end
            default: sw_q <= SW_RUN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_osc_en <= 1'b0;
         pll_pwrdn <= 1'b1;
         sysdiv <= 6'h0f;
         use_sysdiv <= 1'b0;
      end else if (clk_en) begin
         crystal_osc_en <= ~run_clock_cfg_q[sysclk_pkg::CRYSTAL_OSC_DIS_BIT];
         pll_pwrdn <= cfg.pwrdn; // [RL9]
         sysdiv <= cfg.sysdiv;
         use_sysdiv <= run_clock_cfg_q[sysclk_pkg::USESYS_BIT];
      end
   end

endmodule

// file: testbench/sysclk_ctrl_props.sv
// port-level checks of the clock select and pll control block
// assumes it is bound onto sysclk_ctrl, one pclk domain
module sysclk_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [5:0] clk_sel,
   input wire logic pll_pwrdn,
   input wire logic [13:0] pll_translation_value
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_state: assert property ($rose(presetn) |->
      clk_sel == 6'h02 && pll_pwrdn && pll_translation_value == 14'h43)
      else $error("wrong state after reset");
   a_sel_onehot: assert property ($onehot0(clk_sel))
      else $error("more than one clock lane selected");
   a_switch_gap: assert property ($fell(|clk_sel) |->
      (clk_sel == 6'h00) [*5] ##1 (clk_sel != 6'h00))
      else $error("clock switch gap wrong");
   a_pll_blocked: assert property ($fell(pll_pwrdn) |=> (!clk_sel[5]) [*8])
      else $error("pll selected before relock");
   a_pwrdn_drop: assert property ($rose(pll_pwrdn) |-> ##[0:4] !clk_sel[5])
      else $error("pll still selected when powered down");
   a_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data outside answer");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h00000000)
      else $error("error answer malformed");
   c_pll_used: cover property (clk_sel[5]);
   c_err_seen: cover property (pslverr);
   c_slow_used: cover property (clk_sel[3]);
endmodule

bind sysclk_ctrl sysclk_ctrl_props u_props (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .clk_sel(clk_sel),
   .pll_pwrdn(pll_pwrdn),
   .pll_translation_value(pll_translation_value)
);

// file: testbench/tb_sysclk_ctrl.sv
// self-checking bench of the clock select and pll control block
// assumes the bench is the apb master and makes the crystal at pclk/4
module tb_sysclk_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, crystal_osc_en, pll_pwrdn, use_sysdiv, irq;
   logic crystal_osc_in = 1'b0;
   logic crystal_select_run = 1'b0;
   logic [1:0] xdiv = 2'h0;
   logic [5:0] clk_sel, sysdiv;
   logic [13:0] pll_translation_value;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   // crystal 4, src crystal, pll on, no bypass
   localparam logic [31:0] CFG_PLL = 32'h07800100;
   localparam int RELOCK = 32'h1200 * 4;

   sysclk_ctrl u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .crystal_osc_in(crystal_osc_in), .clk_sel(clk_sel),
      .crystal_osc_en(crystal_osc_en), .pll_pwrdn(pll_pwrdn),
      .pll_translation_value(pll_translation_value), .sysdiv(sysdiv),
      .use_sysdiv(use_sysdiv), .irq(irq));

   always #2 pclk = ~pclk;
   // crystal stands still until the relock tests need it
   always @(posedge pclk) begin
      if (crystal_select_run) begin
         xdiv <= xdiv + 2'h1;
         crystal_osc_in <= xdiv[1];
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      chk(r, exp);
   endtask
   task automatic wait_sel(input logic [5:0] exp, input int max);
      int n;
      n = 0;
      while (clk_sel !== exp && n < max) begin
         @(posedge pclk);
         n++;
      end
      chk({26'h0, clk_sel}, {26'h0, exp});
   endtask

   task automatic t_reset;
      chk({26'h0, clk_sel}, 32'h02);
      chk({31'h0, pll_pwrdn}, 32'h1);
      chk({18'h0, pll_translation_value}, 32'h43);
      chk({31'h0, crystal_osc_en}, 32'h0);
      chk({31'h0, use_sysdiv}, 32'h0);
      rd(sysclk_pkg::RUN_CLOCK_CFG_OFF, sysclk_pkg::RUN_CLOCK_CFG_RST);
      rd(sysclk_pkg::RUN_CLOCK_CFG_EXT_OFF, sysclk_pkg::RUN_CLOCK_CFG_EXT_RST);
      rd(sysclk_pkg::RIS_OFF, 32'h0);
   endtask
   task automatic t_unmapped;
      logic [31:0] r;
      logic e;
      apb(12'h0fc, 1'b1, 32'hffffffff, r, e);
      chk({31'h0, e}, 32'h1);
      apb(12'h0fc, 1'b0, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
   endtask
   task automatic t_ext;
      // slow source, divisor 0x2a, bypass and pll off
      wr(sysclk_pkg::RUN_CLOCK_CFG_EXT_OFF, 32'h95002830);
      // clock enable low freezes the switch before it starts
      clk_en <= 1'b0;
      repeat (20) @(posedge pclk);
      chk({26'h0, clk_sel}, 32'h02);
      chk({26'h0, sysdiv}, 32'h0f);
      clk_en <= 1'b1;
      wait_sel(6'h08, 20);
      chk({26'h0, sysdiv}, 32'h2a);
      wr(sysclk_pkg::RUN_CLOCK_CFG_EXT_OFF, 32'h15002830);
      wait_sel(6'h02, 20);
      chk({26'h0, sysdiv}, 32'h0f);
   endtask
   task automatic t_relock;
      wr(sysclk_pkg::IMC_OFF, 32'h40);
      // crystal enabled first and left to settle while the fast source runs
      wr(sysclk_pkg::RUN_CLOCK_CFG_OFF, CFG_PLL | 32'h00002010);
      crystal_select_run <= 1'b1;
      repeat (40) @(posedge pclk);
      chk({31'h0, crystal_osc_en}, 32'h1);
      chk({26'h0, clk_sel}, 32'h02);
      chk({31'h0, pll_pwrdn}, 32'h1);
      wr(sysclk_pkg::RUN_CLOCK_CFG_OFF, CFG_PLL);
      repeat (4) @(posedge pclk);
      chk({18'h0, pll_translation_value}, 32'h70);
      rd(sysclk_pkg::PLL_TRANSLATION_OFF, 32'h70);
      chk({31'h0, pll_pwrdn}, 32'h0);
      // counter must not end early
      repeat (RELOCK - 300) @(posedge pclk);
      chk({26'h0, clk_sel}, 32'h01);
      chk({31'h0, irq}, 32'h0);
      wait_sel(6'h20, 1000);
      chk({31'h0, irq}, 32'h1);
      rd(sysclk_pkg::RIS_OFF, 32'h40);
      rd(sysclk_pkg::MISC_OFF, 32'h40);
      wr(sysclk_pkg::RUN_CLOCK_CFG_OFF, CFG_PLL);
      repeat (20) @(posedge pclk);
      chk({26'h0, clk_sel}, 32'h20);
      wr(sysclk_pkg::MISC_OFF, 32'h40);
      rd(sysclk_pkg::RIS_OFF, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // masked: lock must not reach irq
      wr(sysclk_pkg::IMC_OFF, 32'h0);
      wr(sysclk_pkg::RUN_CLOCK_CFG_OFF, CFG_PLL | 32'h40);
      wait_sel(6'h01, 20);
      chk({18'h0, pll_translation_value}, 32'h6d);
      wait_sel(6'h20, RELOCK + 1000);
      chk({31'h0, irq}, 32'h0);
      rd(sysclk_pkg::RIS_OFF, 32'h40);
      wr(sysclk_pkg::RUN_CLOCK_CFG_OFF, CFG_PLL | 32'h00402040);
      wait_sel(6'h01, 20);
      chk({31'h0, pll_pwrdn}, 32'h1);
      chk({31'h0, use_sysdiv}, 32'h1);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_unmapped();
      t_ext();
      t_relock();
      give_verdict();
   end
endmodule
